// ---- rtl/clk_prescaler.sv ----
// Prescaler that divides the main clock for CPU and peripherals
`timescale 1ns/100ps
module clk_prescaler (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Control
   input  wire logic                 run_in,
   input  wire logic [2:0]           sel_in,
   // Divided outputs
   output logic [clkgen_pkg::DIV_WIDTH-1:0] cnt_out,
   output logic                      tick_out
);
   import clkgen_pkg::*;

   logic [DIV_WIDTH-1:0] cnt_r, cnt_nxt;
   logic                 tick_r, tick_nxt;
   logic [3:0]           mask;

   // Ratio 2^sel: a tick whenever the low sel bits are all ones
   always_comb begin
      mask     = 4'h0;
      case (sel_in)
         3'h1:    mask = 4'h1;
         3'h2:    mask = 4'h3;
         3'h3:    mask = 4'h7;
         3'h4:    mask = 4'hF;
         default: mask = 4'h0;
      endcase
      // Divider freezes when the oscillator stops
      cnt_nxt  = run_in ? cnt_r + 8'h01 : cnt_r;
      tick_nxt = run_in && ((cnt_r[3:0] & mask) == mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign cnt_out  = cnt_r;
   assign tick_out = tick_r;

endmodule : clk_prescaler

// ---- rtl/clkgen_pkg.sv ----
// Package: constants, types and helpers for the CPU clock generator
// Overview of operation
// - Reset loads the select register with 04H, the divide-by-sixteen ratio.
// - Select codes 000..100 give divide by 1, 2, 4, 8, 16; others forbidden.
// - Shortest instruction lasts two CPU clock periods.
// - Old ratio is kept for 16, 8, 4, 2 or 1 instructions after a write.
// - Each counted instruction lasts one minimum instruction time at old ratio.
// - Main oscillation is stopped while the reset input is low.
// - After reset, wait 2^16 main clocks, then run at the slowest ratio.
// - Peripheral clocks are divided from the main clock and stop with it.
// - Select register is read/write with bit and byte write operations.
// - Clock generator manages the STOP and HALT standby modes.
// - The STOP instruction halts the main oscillator.
package clkgen_pkg;

   // Register map
   localparam logic [15:0] SEL_REG_ADDR   = 16'hFFFB;
   localparam logic [2:0]  SEL_RESET_VAL  = 3'h4;
   localparam logic [2:0]  SEL_MAX_CODE   = 3'h4;
   localparam logic [7:0]  RD_IDLE_VAL    = 8'h00;

   // Timing figures in main or CPU clock cycles, and divider width
   localparam int          STAB_CYCLES_DEF = 65536;
   localparam logic [1:0]  CPU_CLKS_PER_INSTR = 2'h2;
   localparam int          DIV_WIDTH      = 8;

   // Register access from the core, one request per cycle
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;       // Byte write
      logic        bit_wr;   // Single bit write
      logic [2:0]  bit_sel;
      logic        bit_val;
      logic [7:0]  wdata;
      logic        rd;
   } reg_req_t;

   typedef enum {ST_STAB, ST_RUN, ST_HALT, ST_STOP} gen_state_t;

   // Instructions the old ratio is held for after a rewrite
   function automatic logic [4:0] switch_delay(input logic [2:0] sel);
      case (sel)
         3'h0:    switch_delay = 5'h10;
         3'h1:    switch_delay = 5'h08;
         3'h2:    switch_delay = 5'h04;
         3'h3:    switch_delay = 5'h02;
         default: switch_delay = 5'h01;
      endcase
   endfunction : switch_delay

endpackage : clkgen_pkg

// ---- rtl/cpu_clock_divider_control.sv ----
// CPU clock divider control with standby and ratio switch delay
`timescale 1ns/100ps
module cpu_clock_divider_control #(
   parameter int STAB_CYCLES = clkgen_pkg::STAB_CYCLES_DEF
) (
   // Main clock and reset
   input  wire logic                 CLK_IN,
   input  wire logic                 RESET_N_IN,
   // Register access from the core
   input  wire clkgen_pkg::reg_req_t REG_REQ_IN,
   output logic [7:0]                RDATA_OUT,
   // Core status strobes
   input  wire logic                 INSTR_DONE_IN,
   input  wire logic                 STOP_EXEC_IN,
   input  wire logic                 HALT_EXEC_IN,
   input  wire logic                 WAKE_IN,
   // Clock outputs
   output logic                      OSC_RUN_OUT,
   output logic                      CPU_CLK_EN_OUT,
   output logic                      CPU_RUN_OUT,
   output logic [2:0]                CPU_DIV_SEL_OUT,
   output logic [clkgen_pkg::DIV_WIDTH-1:0] PERIPH_DIV_OUT
);
   import clkgen_pkg::*;

   gen_state_t  state_r, state_nxt;
   logic [16:0] stab_r, stab_nxt;
   logic        osc_r, osc_nxt;
   logic [2:0]  sel_r, sel_nxt;
   logic [2:0]  act_r, act_nxt;
   logic        pend_r, pend_nxt;
   logic [4:0]  dly_r, dly_nxt;
   logic [1:0]  phase_r, phase_nxt;
   logic        cpu_en_r, cpu_en_nxt;
   logic        run_r, run_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        tick;
   logic [DIV_WIDTH-1:0] div_cnt;
   logic        hit, instr_tick;
   logic [7:0]  wr_byte;
   logic        wr_ok;

   // Divider runs only while the oscillator runs
   clk_prescaler u_prescaler (
      .clk      (CLK_IN),
      .rst_n    (RESET_N_IN),
      .run_in   (osc_r),
      .sel_in   (act_r),
      .cnt_out  (div_cnt),
      .tick_out (tick)
   );

   assign hit = (REG_REQ_IN.addr == SEL_REG_ADDR);

   // Standby and oscillation stabilization sequencing
   always_comb begin
      state_nxt = state_r;
      stab_nxt  = stab_r;
      osc_nxt   = osc_r;
      case (state_r)
         ST_STAB: begin
            osc_nxt = 1'b1;
            if (stab_r == 17'(STAB_CYCLES - 1)) begin
               state_nxt = ST_RUN;
               stab_nxt  = 17'h00000;
            end else begin
               stab_nxt  = stab_r + 17'h00001;
            end
         end
         ST_RUN: begin
            if (STOP_EXEC_IN) begin
               state_nxt = ST_STOP;
               osc_nxt   = 1'b0;
            end else if (HALT_EXEC_IN) begin
               state_nxt = ST_HALT;
            end
         end
         ST_HALT: begin
            // Oscillator keeps running so wake up is immediate
            if (WAKE_IN) begin
               state_nxt = ST_RUN;
            end
         end
         ST_STOP: begin
            // Resonator must settle again before the core resumes
            if (WAKE_IN) begin
               state_nxt = ST_STAB;
               osc_nxt   = 1'b1;
            end
         end
         default: state_nxt = ST_STAB;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_r <= ST_STAB;
         stab_r  <= 17'h00000;
         osc_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         stab_r  <= stab_nxt;
         osc_r   <= osc_nxt;
      end
   end

   // CPU clock enable and minimum instruction time phase
   always_comb begin
      run_nxt    = (state_nxt == ST_RUN);
      cpu_en_nxt = tick && (state_r == ST_RUN);
      phase_nxt  = phase_r;
      instr_tick = 1'b0;
      if (cpu_en_r) begin
         // Two CPU clocks form the shortest instruction
         if (phase_r == CPU_CLKS_PER_INSTR - 2'h1) begin
            phase_nxt  = 2'h0;
            instr_tick = 1'b1;
         end else begin
            phase_nxt  = phase_r + 2'h1;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         run_r    <= 1'b0;
         cpu_en_r <= 1'b0;
         phase_r  <= 2'h0;
      end else begin
         run_r    <= run_nxt;
         cpu_en_r <= cpu_en_nxt;
         phase_r  <= phase_nxt;
      end
   end

   // Write decode: a byte write wins over a bit write; bit writes only
   // reach the three select bits, so higher positions are simply dropped
   always_comb begin
      wr_byte = {5'h00, sel_r};
      wr_ok   = 1'b0;
      if (REG_REQ_IN.bit_wr && REG_REQ_IN.bit_sel < 3'h3) begin
         wr_byte[REG_REQ_IN.bit_sel] = REG_REQ_IN.bit_val;
         wr_ok                       = 1'b1;
      end
      if (REG_REQ_IN.wr) begin
         wr_byte = REG_REQ_IN.wdata;
         wr_ok   = 1'b1;
      end
      // Forbidden codes are refused whole, so no switch is armed by them
      wr_ok = wr_ok && hit && (wr_byte[2:0] <= SEL_MAX_CODE);
   end

   // Select register and read back
   always_comb begin
      sel_nxt   = sel_r;
      rdata_nxt = RD_IDLE_VAL;
      if (wr_ok) begin
         sel_nxt = wr_byte[2:0];
      end
      if (hit && REG_REQ_IN.rd) begin
         rdata_nxt = {5'h00, sel_r};
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sel_r   <= SEL_RESET_VAL;
         rdata_r <= RD_IDLE_VAL;
      end else begin
         sel_r   <= sel_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Pending ratio switch, counted in instructions at the old ratio.
   // The switch takes the newest select value, so a rewrite landing on
   // the closing count is applied rather than lost.
   always_comb begin
      act_nxt  = act_r;
      pend_nxt = pend_r;
      dly_nxt  = dly_r;
      // Count down at the old ratio: strobe or elapsed instruction time
      if (pend_r && (INSTR_DONE_IN || instr_tick)) begin
         if (dly_r == 5'h01) begin
            act_nxt  = sel_nxt;
            pend_nxt = 1'b0;
         end else begin
            dly_nxt  = dly_r - 5'h01;
         end
      end
      // A rewrite during a pending switch does not restart the count
      if (wr_ok && !pend_r) begin
         pend_nxt = 1'b1;
         dly_nxt  = switch_delay(act_r);
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         act_r  <= SEL_RESET_VAL;
         pend_r <= 1'b0;
         dly_r  <= 5'h00;
      end else begin
         act_r  <= act_nxt;
         pend_r <= pend_nxt;
         dly_r  <= dly_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign RDATA_OUT       = rdata_r;
   assign OSC_RUN_OUT     = osc_r;
   assign CPU_CLK_EN_OUT  = cpu_en_r;
   assign CPU_RUN_OUT     = run_r;
   assign CPU_DIV_SEL_OUT = act_r;
   assign PERIPH_DIV_OUT  = div_cnt;

endmodule : cpu_clock_divider_control

// ---- tb/cpu_clock_divider_control_asserts.sv ----
// Checker: port assertions for the CPU clock divider control
`timescale 1ns/100ps
module cpu_clock_divider_control_asserts
   import clkgen_pkg::*;
#(parameter int STAB_CYCLES = 16) (
   input wire logic                 CLK_IN,
   input wire logic                 RESET_N_IN,
   input wire clkgen_pkg::reg_req_t REG_REQ_IN,
   input wire logic [7:0]           RDATA_OUT,
   input wire logic                 STOP_EXEC_IN,
   input wire logic                 HALT_EXEC_IN,
   input wire logic                 OSC_RUN_OUT,
   input wire logic                 CPU_CLK_EN_OUT,
   input wire logic                 CPU_RUN_OUT,
   input wire logic [2:0]           CPU_DIV_SEL_OUT,
   input wire logic [7:0]           PERIPH_DIV_OUT
);
   localparam int LIM = STAB_CYCLES + 3;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   a_reset_stops: assert property (disable iff (1'b0)
      !RESET_N_IN |-> !OSC_RUN_OUT && !CPU_RUN_OUT) else $error("run in reset");
   a_stab_wait: assert property ($rose(OSC_RUN_OUT) |->
      (!CPU_RUN_OUT)[*8] ##[1:LIM] CPU_RUN_OUT) else $error("bad stab wait");
   a_stop_osc: assert property (STOP_EXEC_IN && CPU_RUN_OUT |=>
      !OSC_RUN_OUT && !CPU_RUN_OUT) else $error("stop ignored");
   a_halt_keeps_osc: assert property (HALT_EXEC_IN && !STOP_EXEC_IN
      && CPU_RUN_OUT |=> OSC_RUN_OUT && !CPU_RUN_OUT) else $error("bad halt");
   a_sel_legal: assert property (CPU_DIV_SEL_OUT <= SEL_MAX_CODE)
      else $error("illegal ratio");
   a_rd_upper_zero: assert property (REG_REQ_IN.rd |=>
      RDATA_OUT[7:3] == 5'h00) else $error("upper bits set");
   a_rd_idle: assert property (!(REG_REQ_IN.rd &&
      REG_REQ_IN.addr == SEL_REG_ADDR) |=> RDATA_OUT == RD_IDLE_VAL)
      else $error("stray read data");
   a_slow_period: assert property (CPU_CLK_EN_OUT &&
      CPU_DIV_SEL_OUT == 3'h4 |=> (!CPU_CLK_EN_OUT ||
      CPU_DIV_SEL_OUT != 3'h4)[*8]) else $error("slow period short");
   a_periph_stops: assert property ((!OSC_RUN_OUT)[*3] |->
      $stable(PERIPH_DIV_OUT)) else $error("periph runs in stop");
   c_run: cover property ($rose(CPU_RUN_OUT));
   c_switch: cover property ($changed(CPU_DIV_SEL_OUT));
   c_halt: cover property (HALT_EXEC_IN && CPU_RUN_OUT);
endmodule : cpu_clock_divider_control_asserts

bind cpu_clock_divider_control cpu_clock_divider_control_asserts
   #(.STAB_CYCLES(STAB_CYCLES)) chk (.CLK_IN(CLK_IN),
   .RESET_N_IN(RESET_N_IN), .REG_REQ_IN(REG_REQ_IN), .RDATA_OUT(RDATA_OUT),
   .STOP_EXEC_IN(STOP_EXEC_IN), .HALT_EXEC_IN(HALT_EXEC_IN),
   .OSC_RUN_OUT(OSC_RUN_OUT), .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
   .CPU_RUN_OUT(CPU_RUN_OUT), .CPU_DIV_SEL_OUT(CPU_DIV_SEL_OUT),
   .PERIPH_DIV_OUT(PERIPH_DIV_OUT));

// ---- tb/cpu_core_model.sv ----
// Model of the CPU core that retires instructions on CPU clock enables
`timescale 1ns/100ps
module cpu_core_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // From the clock generator
   input  wire logic clk_en,
   input  wire logic run,
   input  wire logic slow,   // Four CPU clocks per instruction
   // To the clock generator
   output logic      done
);
   logic [1:0] cnt_r;
   // Retire strobe; slow mode checks the internal tick still ends a switch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         done  <= 1'b0;
      end else begin
         done <= run && clk_en && (slow ? cnt_r == 2'h3 : cnt_r[0]);
         if (run && clk_en) begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end
endmodule : cpu_core_model

// ---- tb/test_cpu_clock_divider_control.sv ----
// Testbench for the CPU clock divider control
`timescale 1ns/100ps
module test_cpu_clock_divider_control;
   import clkgen_pkg::*;
   localparam int STAB = 16;   // Short stabilisation keeps the run brief
   logic clk = 1'b0, rst_n = 1'b1, stop = 1'b0, halt = 1'b0;
   logic wake = 1'b0, slow = 1'b0, done, osc, clk_en, run;
   logic [7:0] rdata, periph;
   logic [2:0] div;
   reg_req_t   req = '0;
   int         err_total = 0, check_count = 0;
   // Main clock
   always #50 clk = ~clk;
   cpu_clock_divider_control #(.STAB_CYCLES(STAB)) dut (.CLK_IN(clk),
      .RESET_N_IN(rst_n), .REG_REQ_IN(req), .RDATA_OUT(rdata),
      .INSTR_DONE_IN(done), .STOP_EXEC_IN(stop), .HALT_EXEC_IN(halt),
      .WAKE_IN(wake), .OSC_RUN_OUT(osc), .CPU_CLK_EN_OUT(clk_en),
      .CPU_RUN_OUT(run), .CPU_DIV_SEL_OUT(div), .PERIPH_DIV_OUT(periph));
   cpu_core_model core (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .run(run), .slow(slow), .done(done));
   task check(string name, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // Inputs always move 1 ns after the rising edge
   task cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task acc(logic [15:0] a, logic w, logic b, logic [2:0] bs, logic bv,
            logic [7:0] d, logic r, output logic [7:0] q);
      req = '{a, w, b, bs, bv, d, r};
      cyc(1);
      q = rdata;
      req = '0;
      cyc(1);
   endtask : acc
   task wait_run(output int n);
      n = 0;
      while (run !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
   endtask : wait_run
   task t_reset(int hold);
      int n;
      logic [7:0] q;
      rst_n = 1'b0;
      cyc(hold);
      check("osc_rst", {7'h0, osc}, 8'h00);
      check("div_rst", {5'h0, div}, 8'h04);
      rst_n = 1'b1;
      wait_run(n);
      check("stab", 8'(n), 8'(STAB));
      check("div_start", {5'h0, div}, 8'h04);
      acc(SEL_REG_ADDR, 0, 0, 0, 0, 0, 1, q);
      check("sel_rst", q, 8'h04);
   endtask : t_reset
   // Every ratio: switch within old-ratio instructions, then period
   task t_codes;
      int n;
      logic [7:0] q;
      for (int c = 0; c <= 4; c++) begin
         acc(SEL_REG_ADDR, 1, 0, 0, 0, 8'(c), 0, q);
         n = 2;
         while (div !== 3'(c) && n < 80) begin
            cyc(1);
            n++;
         end
         check("switch", 8'(n <= 35), 8'h01);
         // Ticks launched under the old ratio drain before measuring
         cyc(2);
         n = 0;
         while (clk_en !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
         end
         n = 1;
         cyc(1);
         while (clk_en !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
         end
         check("period", 8'(n), 8'(1 << c));
         acc(SEL_REG_ADDR, 0, 0, 0, 0, 0, 1, q);
         check("readback", q, 8'(c));
      end
   endtask : t_codes
   task t_bad;
      logic [7:0] q;
      slow = 1'b1;
      acc(SEL_REG_ADDR, 1, 0, 0, 0, 8'h05, 1, q);
      acc(SEL_REG_ADDR, 0, 0, 0, 0, 0, 1, q);
      check("bad_code", q, 8'h04);
      acc(SEL_REG_ADDR, 0, 1, 3'h2, 0, 0, 0, q);
      acc(SEL_REG_ADDR, 0, 1, 3'h1, 1, 0, 0, q);
      acc(SEL_REG_ADDR, 0, 1, 3'h5, 1, 0, 1, q);
      check("bit_wr", q, 8'h02);
      acc(16'hFFFA, 0, 0, 0, 0, 0, 1, q);
      check("unmapped", q, 8'h00);
      cyc(40);
      check("bit_sw", {5'h0, div}, 8'h02);
      slow = 1'b0;
   endtask : t_bad
   task t_standby;
      int n;
      logic [7:0] pv;
      halt = 1'b1;
      cyc(1);
      halt = 1'b0;
      check("halt", {6'h0, osc, run}, 8'h02);
      cyc(3);
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      check("halt_wake", {7'h0, run}, 8'h01);
      pv = periph;
      cyc(4);
      check("periph_run", periph, pv + 8'h04);
      // Main clock is taken as resonator fed, so STOP is allowed
      stop = 1'b1;
      cyc(1);
      stop = 1'b0;
      check("stop", {6'h0, osc, run}, 8'h00);
      cyc(2);
      pv = periph;
      cyc(4);
      check("periph", periph, pv);
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      check("stop_wake", {7'h0, osc}, 8'h01);
      wait_run(n);
      check("restab", 8'(n), 8'(STAB));
   endtask : t_standby
   // Main sequence, second reset lands in mid-run
   initial begin
      // A falling edge after time zero is sure to reach the flops
      #1;
      t_reset(5);
      t_codes;
      t_bad;
      t_standby;
      t_reset(3);
      summarize;
   end
   // Watchdog well beyond the expected 275 cycles
   initial begin
      #300000;
      err_total++;
      summarize;
   end
endmodule : test_cpu_clock_divider_control
